//--- rtl/arcu_core.v
`timescale 1ns/1ps
`include "arcu_map.vh"
module arcu_core (
  input  wire        i_clk,
  input  wire        i_resetn,
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [11:0] i_paddr,
  input  wire [31:0] i_pwdata,
  output reg  [31:0] o_prdata,
  output wire        o_pready,
  output wire        o_pslverr,
  input  wire        i_conv_valid,
  input  wire [15:0] i_conversion_result,
  output reg         o_conv_start,
  output reg         o_conversion_done_flag,
  output reg         o_threshold_hit_flag
);
  reg  [2:0]  computation_mode_select_ff;
  reg         double_sample_enable_ff;
  reg  [2:0]  shift_amount_ff;
  reg         clear_request_bit_ff;
  reg  [7:0]  repeat_target_ff;
  reg  [15:0] lower_thresh_ff;
  reg  [15:0] upper_thresh_ff;
  reg  [15:0] result_accumulator_ff;
  reg  [15:0] filtered_output_ff;
  reg  [15:0] result_ff;
  reg  [15:0] first_ff;
  reg         second_ff;
  reg  [7:0]  sample_counter_ff;
  reg         overflow_flag_ff;
  reg         busy_ff;
  reg         tested_ff;
  reg  [15:0] nxt_acc;
  reg  [7:0]  nxt_cnt;
  reg         nxt_ov;
  reg  [16:0] sum;
  reg         do_test;
  reg         sample_ready;
  wire [15:0] sample;
  wire        wr;
  wire        rd_ok;
  wire        go_wr;
  wire        clr_wr;
  wire        hit;
  wire        in_acc_mode;
  wire [15:0] test_value;
  wire        ctrl_wr;
  wire        st_wr;
  wire        setup_rd;
  wire        take_sample;
  wire        restart;
  reg  [31:0] rd_mux;

  assign o_pready  = 1'b1;
  assign wr        = i_psel & i_penable & i_pwrite;
  assign go_wr     = wr & (i_paddr == `ARCU_ADDR_CTRL) & i_pwdata[`ARCU_CTRL_GO_BIT];
  assign clr_wr    = wr & (i_paddr == `ARCU_ADDR_CTRL) & i_pwdata[`ARCU_CTRL_CLR_BIT];
  assign rd_ok     = (i_paddr == `ARCU_ADDR_CTRL) | (i_paddr == `ARCU_ADDR_RPT) |
                     (i_paddr == `ARCU_ADDR_RESULT) | (i_paddr == `ARCU_ADDR_ACC) |
                     (i_paddr == `ARCU_ADDR_FILT) | (i_paddr == `ARCU_ADDR_STATUS) |
                     (i_paddr == `ARCU_ADDR_THRESH);
  assign o_pslverr = i_psel & i_penable & ~rd_ok;
  assign in_acc_mode = (computation_mode_select_ff != `ARCU_MD_BASIC);
  assign ctrl_wr     = wr & (i_paddr == `ARCU_ADDR_CTRL);
  assign st_wr       = wr & (i_paddr == `ARCU_ADDR_STATUS);
  // read data is captured in the setup phase, so zero wait states still hold
  assign setup_rd    = i_psel & ~i_penable & ~i_pwrite;
  // a go or a pending clear owns the cycle; a result arriving then is dropped
  assign take_sample = sample_ready & ~go_wr & ~clear_request_bit_ff;
  // average restarts only after a finished test, burst at every trigger
  assign restart     = ((computation_mode_select_ff == `ARCU_MD_AVG) & tested_ff) |
                       (computation_mode_select_ff == `ARCU_MD_BURST);

  // second minus first when double sampling
  assign sample = double_sample_enable_ff ? (i_conversion_result - first_ff)
                                          : i_conversion_result;

  // go bit reads as zero: it is a strobe, not a state
  always @* begin
    rd_mux = 32'h0000_0000;
    case (i_paddr)
      `ARCU_ADDR_CTRL:   rd_mux = {22'h0, 1'b0, clear_request_bit_ff, 1'b0,
                                  shift_amount_ff, double_sample_enable_ff,
                                  computation_mode_select_ff};
      `ARCU_ADDR_RPT:    rd_mux = {24'h0, repeat_target_ff};
      `ARCU_ADDR_RESULT: rd_mux = {16'h0, result_ff};
      `ARCU_ADDR_ACC:    rd_mux = {16'h0, result_accumulator_ff};
      `ARCU_ADDR_FILT:   rd_mux = {16'h0, filtered_output_ff};
      `ARCU_ADDR_STATUS: rd_mux = {16'h0, sample_counter_ff, 4'h0, busy_ff, overflow_flag_ff,
                                  o_threshold_hit_flag, o_conversion_done_flag};
      `ARCU_ADDR_THRESH: rd_mux = {upper_thresh_ff, lower_thresh_ff};
      default:           rd_mux = 32'h0000_0000;
    endcase
  end

  // a flag set during the access phase shows on the next read, not this one
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_prdata <= 32'h0000_0000;
    end else if (setup_rd) begin
      o_prdata <= rd_mux;
    end
  end

  // per-sample accumulation step
  always @* begin
    nxt_acc      = result_accumulator_ff;
    nxt_cnt      = sample_counter_ff;
    nxt_ov       = overflow_flag_ff;
    sum          = 17'h0_0000;
    do_test      = 1'b0;
    sample_ready = i_conv_valid & (~double_sample_enable_ff | second_ff);
    if (sample_ready) begin
      case (computation_mode_select_ff)
        `ARCU_MD_BASIC: begin
          do_test = 1'b1;
        end
        `ARCU_MD_ACCUM, `ARCU_MD_AVG, `ARCU_MD_BURST: begin
          sum     = {1'b0, result_accumulator_ff} + {1'b0, sample};
          nxt_acc = sum[15:0];
          if (sum[16])
            nxt_ov = 1'b1;
          if (sample_counter_ff != `ARCU_CNT_MAX)
            nxt_cnt = sample_counter_ff + 8'h01;
          if (computation_mode_select_ff == `ARCU_MD_ACCUM)
            do_test = 1'b1;
          else
            do_test = (nxt_cnt >= repeat_target_ff);
        end
        `ARCU_MD_LPF: begin
          // acc + s - acc>>shift, the recursive pole
          sum     = {1'b0, result_accumulator_ff} + {1'b0, sample}
                    - {1'b0, (result_accumulator_ff >> shift_amount_ff)};
          nxt_acc = sum[15:0];
          if (sum[16])
            nxt_ov = 1'b1;
          if (sample_counter_ff != `ARCU_CNT_MAX)
            nxt_cnt = sample_counter_ff + 8'h01;
          do_test = (nxt_cnt >= repeat_target_ff);
        end
        default: do_test = 1'b0;
      endcase
    end
  end

  assign test_value = in_acc_mode ? (nxt_acc >> shift_amount_ff) : sample;
  arcu_thresh u_thresh (
    .i_value (test_value),
    .i_lower (lower_thresh_ff),
    .i_upper (upper_thresh_ff),
    .i_ov    (nxt_ov & in_acc_mode),
    .o_hit   (hit)
  );

  // software configuration
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      computation_mode_select_ff <= `ARCU_MD_BASIC;
      double_sample_enable_ff    <= 1'b0;
      shift_amount_ff            <= 3'h0;
      repeat_target_ff           <= `ARCU_RST_RPT;
      lower_thresh_ff            <= 16'h0000;
      upper_thresh_ff            <= 16'h0000;
    end else begin
      if (ctrl_wr) begin
        computation_mode_select_ff <= i_pwdata[`ARCU_CTRL_MD_MSB:`ARCU_CTRL_MD_LSB];
        double_sample_enable_ff    <= i_pwdata[`ARCU_CTRL_DS_BIT];
        shift_amount_ff            <= i_pwdata[`ARCU_CTRL_SH_MSB:`ARCU_CTRL_SH_LSB];
      end
      if (wr && i_paddr == `ARCU_ADDR_RPT) begin
        repeat_target_ff <= i_pwdata[7:0];
      end
      if (wr && i_paddr == `ARCU_ADDR_THRESH) begin
        lower_thresh_ff <= i_pwdata[15:0];
        upper_thresh_ff <= i_pwdata[31:16];
      end
    end
  end

  // pair tracking: odd result is stored, even result completes the pair
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      result_ff <= 16'h0000;
      first_ff  <= 16'h0000;
      second_ff <= 1'b0;
    end else begin
      if (i_conv_valid) begin
        result_ff <= i_conversion_result;
        if (double_sample_enable_ff) begin
          second_ff <= ~second_ff;
          if (!second_ff) begin
            first_ff <= i_conversion_result;
          end
        end else begin
          second_ff <= 1'b0;
        end
      end
      // leaving double sampling forgets a half pair, so the next pair starts clean
      if (ctrl_wr && !i_pwdata[`ARCU_CTRL_DS_BIT]) begin
        second_ff <= 1'b0;
      end
    end
  end

  // accumulator, counter, overflow and the clear request
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      clear_request_bit_ff  <= 1'b0;
      result_accumulator_ff <= 16'h0000;
      filtered_output_ff    <= 16'h0000;
      sample_counter_ff     <= 8'h00;
      overflow_flag_ff      <= 1'b0;
      tested_ff             <= 1'b0;
    end else begin
      if (go_wr) begin
        if (restart) begin
          result_accumulator_ff <= 16'h0000;
          sample_counter_ff     <= 8'h00;
          overflow_flag_ff      <= 1'b0;
          tested_ff             <= 1'b0;
        end
      end else if (clear_request_bit_ff) begin
        // a go in the same cycle defers the clear by one cycle
        result_accumulator_ff <= 16'h0000;
        sample_counter_ff     <= 8'h00;
        overflow_flag_ff      <= 1'b0;
        filtered_output_ff    <= 16'h0000;
        clear_request_bit_ff  <= 1'b0;
        tested_ff             <= 1'b0;
      end else if (take_sample) begin
        result_accumulator_ff <= nxt_acc;
        sample_counter_ff     <= nxt_cnt;
        overflow_flag_ff      <= nxt_ov;
        if (in_acc_mode) begin
          filtered_output_ff <= nxt_acc >> shift_amount_ff;
        end
        if (do_test) begin
          tested_ff <= 1'b1;
        end
      end
      if (clr_wr) begin
        clear_request_bit_ff <= 1'b1;
      end
    end
  end

  // status flags: write one to clear, a hardware set in the same cycle wins
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_conversion_done_flag <= 1'b0;
      o_threshold_hit_flag   <= 1'b0;
    end else begin
      if (st_wr && i_pwdata[`ARCU_ST_DONE_BIT]) begin
        o_conversion_done_flag <= 1'b0;
      end
      if (st_wr && i_pwdata[`ARCU_ST_THR_BIT]) begin
        o_threshold_hit_flag <= 1'b0;
      end
      if (take_sample) begin
        o_conversion_done_flag <= 1'b1;
      end
      if (take_sample && do_test && hit) begin
        o_threshold_hit_flag <= 1'b1;
      end
    end
  end

  // converter start: software go or burst retrigger, one cycle each
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_conv_start <= 1'b0;
      busy_ff      <= 1'b0;
    end else begin
      o_conv_start <= 1'b0;
      if (go_wr) begin
        o_conv_start <= 1'b1;
        busy_ff      <= 1'b1;
      end else if (take_sample) begin
        if (computation_mode_select_ff == `ARCU_MD_BURST && !do_test) begin
          o_conv_start <= 1'b1;
        end else begin
          busy_ff <= 1'b0;
        end
      end
    end
  end
endmodule // arcu_core

//--- rtl/arcu_map.vh
`ifndef ARCU_MAP_VH
`define ARCU_MAP_VH
// apb byte addresses
`define ARCU_ADDR_CTRL    12'h000
`define ARCU_ADDR_RPT     12'h004
`define ARCU_ADDR_RESULT  12'h008
`define ARCU_ADDR_ACC     12'h00c
`define ARCU_ADDR_FILT    12'h010
`define ARCU_ADDR_STATUS  12'h014
`define ARCU_ADDR_THRESH  12'h018
// ctrl fields
`define ARCU_CTRL_MD_LSB  0
`define ARCU_CTRL_MD_MSB  2
`define ARCU_CTRL_DS_BIT  3
`define ARCU_CTRL_SH_LSB  4
`define ARCU_CTRL_SH_MSB  6
`define ARCU_CTRL_CLR_BIT 8
`define ARCU_CTRL_GO_BIT  9
// status fields
`define ARCU_ST_DONE_BIT  0
`define ARCU_ST_THR_BIT   1
`define ARCU_ST_OV_BIT    2
`define ARCU_ST_CNT_LSB   8
// modes
`define ARCU_MD_BASIC     3'h0
`define ARCU_MD_ACCUM     3'h1
`define ARCU_MD_AVG       3'h2
`define ARCU_MD_BURST     3'h3
`define ARCU_MD_LPF       3'h4
// reset value and counter limit
`define ARCU_RST_RPT      8'h01
`define ARCU_CNT_MAX      8'hff
`endif

//--- rtl/arcu_thresh.v
`timescale 1ns/1ps
// signed window compare of the value under test
module arcu_thresh (
  input  wire [15:0] i_value,
  input  wire [15:0] i_lower,
  input  wire [15:0] i_upper,
  input  wire        i_ov,
  output wire        o_hit
);
  wire above_low;
  wire below_up;
  assign above_low = ($signed(i_value) >= $signed(i_lower));
  assign below_up  = ($signed(i_value) <= $signed(i_upper));
  // overflow forces a hit so software sees the bad sum
  assign o_hit = (above_low & below_up) | i_ov;
endmodule // arcu_thresh

//--- verif/arcu_adc_model.sv
`timescale 1ns/1ps
// converter stand-in: answers each start after 2 or 6 cycles
module arcu_adc_model (
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_start,
  input  wire logic        i_slow,
  output logic             o_valid,
  output logic [15:0]      o_result
);
  logic [15:0] data [0:63];
  logic [5:0]  idx;
  int          n_done;
  int          wait_n;
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_valid <= 1'b0;
      o_result <= 16'h0;
      idx <= 6'h0;
      n_done <= 0;
      wait_n <= 0;
    end else begin
      o_valid <= 1'b0;
      // result line is not held once the pulse is over
      o_result <= ~o_result;
      if (i_start) wait_n <= i_slow ? 6 : 2;
      else if (wait_n > 0) wait_n <= wait_n - 1;
      if (!i_start && wait_n == 1) begin
        o_valid <= 1'b1;
        o_result <= data[idx];
        idx <= idx + 6'h1;
        n_done <= n_done + 1;
      end
    end
  end
endmodule // arcu_adc_model

//--- verif/arcu_core_asserts.sv
`timescale 1ns/1ps
module arcu_core_asserts (
  input wire logic        i_clk,
  input wire logic        i_resetn,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic        i_conv_valid,
  input wire logic        o_conv_start,
  input wire logic        o_conversion_done_flag,
  input wire logic        o_threshold_hit_flag
);
  logic [2:0] md_ff;
  logic       ds_ff;
  logic       ph_ff;
  wire wr = i_psel && i_penable && i_pwrite;
  wire wr_ctrl = wr && i_paddr == 12'h000;
  wire wr_st = wr && i_paddr == 12'h014;
  wire go = wr_ctrl && i_pwdata[9];
  // mode and pair phase mirrored, the core keeps them inside
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      md_ff <= 3'h0;
      ds_ff <= 1'b0;
      ph_ff <= 1'b0;
    end else begin
      if (wr_ctrl) md_ff <= i_pwdata[2:0];
      if (wr_ctrl) ds_ff <= i_pwdata[3];
      if (wr_ctrl && !i_pwdata[3]) ph_ff <= 1'b0;
      else if (i_conv_valid && ds_ff) ph_ff <= ~ph_ff;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  AST_GO_START: assert property (go |=> o_conv_start) else $error("no start after go");
  AST_ACC_DONE: assert property (md_ff == 3'h1 && i_conv_valid && (!ds_ff || ph_ff)
    |=> o_conversion_done_flag)
    else $error("accumulate done missing");
  AST_DS_FIRST: assert property (md_ff == 3'h0 && ds_ff && !ph_ff && i_conv_valid
    && !o_conversion_done_flag |=> !o_conversion_done_flag) else $error("done on first");
  AST_ONE_DONE: assert property (md_ff == 3'h0 && !ds_ff && i_conv_valid
    |=> o_conversion_done_flag) else $error("basic done missing");
  AST_NO_RETRIG: assert property (md_ff != 3'h3 && i_conv_valid && !go |=> !o_conv_start)
    else $error("retrigger outside burst");
  AST_THR_HOLD: assert property (o_threshold_hit_flag && !(wr_st && i_pwdata[1])
    |=> o_threshold_hit_flag) else $error("threshold flag lost");
  AST_DONE_HOLD: assert property (o_conversion_done_flag && !(wr_st && i_pwdata[0])
    |=> $stable(o_conversion_done_flag)) else $error("done flag lost");
  AST_ST_READ: assert property (i_psel && !i_penable && !i_pwrite && i_paddr == 12'h014
    |=> o_prdata[1] == $past(o_threshold_hit_flag) && o_prdata[0] == $past(o_conversion_done_flag))
    else $error("status");
  cover property (md_ff == 3'h3 && o_conv_start && !$past(go));
  cover property (ds_ff && ph_ff && i_conv_valid);
  cover property ($rose(o_threshold_hit_flag));
endmodule // arcu_core_asserts
bind arcu_core arcu_core_asserts u_chk (.i_clk(i_clk), .i_resetn(i_resetn), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
  .o_prdata(o_prdata), .i_conv_valid(i_conv_valid), .o_conv_start(o_conv_start),
  .o_conversion_done_flag(o_conversion_done_flag), .o_threshold_hit_flag(o_threshold_hit_flag));

//--- verif/arcu_core_bench.sv
`timescale 1ns/1ps
module arcu_core_bench;
  logic        i_clk = 0, i_resetn = 0, psel = 0, pen = 0, pwr = 0, slow = 0;
  logic [11:0] addr = 12'h0;
  logic [31:0] wdata = 32'h0, rdata, rd_v, ctrl;
  logic [15:0] res;
  logic        vld, start, done, thr, ready, err, e_v;
  logic [5:0]  p = 6'h0;
  int          n_mismatch = 0, checks = 0, tgt;
  always #25 i_clk = ~i_clk;
  arcu_core u_dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wdata), .o_prdata(rdata), .o_pready(ready),
    .o_pslverr(err), .i_conv_valid(vld), .i_conversion_result(res), .o_conv_start(start),
    .o_conversion_done_flag(done), .o_threshold_hit_flag(thr));
  arcu_adc_model u_adc (.i_clk(i_clk), .i_resetn(i_resetn), .i_start(start), .i_slow(slow),
    .o_valid(vld), .o_result(res));
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk);
    {psel, pwr, addr, wdata} <= {1'b1, w, a, d};
    @(posedge i_clk);
    pen <= 1'b1;
    @(posedge i_clk);
    while (ready !== 1'b1) @(posedge i_clk);
    rd_v = rdata;
    e_v = err;
    {psel, pen} <= 2'b00;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rchk(input string n, input logic [11:0] a, input logic [31:0] m, e);
    xfer(1'b0, a, 32'h0);
    chk(n, e, rd_v & m);
  endtask
  task automatic mode(input logic [31:0] v);
    ctrl = v & 32'hff;
    xfer(1'b1, 12'h000, v);
  endtask
  // one trigger, n results queued for the converter
  task automatic go(input int n, input logic [15:0] v);
    for (int i = 0; i < n; i++) begin
      u_adc.data[p] = v;
      p++;
    end
    tgt = u_adc.n_done + n;
    xfer(1'b1, 12'h000, ctrl | 32'h200);
    while (u_adc.n_done < tgt) @(posedge i_clk);
    repeat (2) @(posedge i_clk);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge i_clk);
    n_mismatch++;
    close_out;
  end
  initial begin
    repeat (6) @(posedge i_clk);
    i_resetn <= 1'b1;
    rchk("rpt", 12'h004, 32'hff, 32'h1);
    chk("pready", 32'h1, {31'h0, ready});
    rchk("hole", 12'h01c, 32'hffffffff, 32'h0);
    chk("slverr", 32'h1, {31'h0, e_v});
    xfer(1'b1, 12'h018, 32'h7fff7fff);
    mode(32'h11);
    go(1, 16'h000a);
    go(1, 16'h0014);
    rchk("acc", 12'h00c, 32'hffff, 32'h1e);
    rchk("filt", 12'h010, 32'hffff, 32'hf);
    rchk("st", 12'h014, 32'hff05, 32'h201);
    go(1, 16'hfff0);
    rchk("ovf", 12'h014, 32'hff07, 32'h307);
    mode(32'h111);
    rchk("clrbit", 12'h000, 32'h100, 32'h0);
    rchk("acc0", 12'h00c, 32'hffff, 32'h0);
    rchk("st0", 12'h014, 32'hff04, 32'h0);
    xfer(1'b1, 12'h018, 32'h00070007);
    xfer(1'b1, 12'h014, 32'h3);
    mode(32'h8);
    go(1, 16'h0005);
    rchk("ds1", 12'h014, 32'hff03, 32'h0);
    go(1, 16'h000c);
    rchk("ds2", 12'h014, 32'hff03, 32'h3);
    chk("done pin", 32'h1, {31'h0, done});
    chk("thr pin", 32'h1, {31'h0, thr});
    rchk("bacc", 12'h00c, 32'hffff, 32'h0);
    xfer(1'b1, 12'h018, 32'h0005fffb);
    mode(32'h0);
    xfer(1'b1, 12'h014, 32'h3);
    go(1, 16'h0009);
    rchk("thr out", 12'h014, 32'h2, 32'h0);
    go(1, 16'hfffe);
    rchk("thr neg", 12'h014, 32'h2, 32'h2);
    mode(32'h102);
    xfer(1'b1, 12'h004, 32'h2);
    xfer(1'b1, 12'h014, 32'h3);
    go(1, 16'h0001);
    rchk("avg1", 12'h014, 32'h2, 32'h0);
    go(1, 16'h0002);
    rchk("avg2", 12'h014, 32'h2, 32'h2);
    go(1, 16'h0004);
    rchk("avg3", 12'h014, 32'hff00, 32'h100);
    rchk("avgacc", 12'h00c, 32'hffff, 32'h4);
    mode(32'h103);
    xfer(1'b1, 12'h004, 32'h3);
    slow <= 1'b1;
    go(3, 16'h0002);
    go(3, 16'h0002);
    rchk("bst", 12'h00c, 32'hffff, 32'h6);
    rchk("bstn", 12'h014, 32'hff00, 32'h300);
    rchk("busy", 12'h014, 32'h8, 32'h0);
    mode(32'h114);
    rchk("ctrl", 12'h000, 32'h17f, 32'h14);
    go(1, 16'h0008);
    go(1, 16'h0008);
    rchk("lpf", 12'h00c, 32'hffff, 32'hc);
    mode(32'h101);
    for (int i = 0; i < 256; i++) go(1, 16'h0000);
    rchk("sat", 12'h014, 32'hff00, 32'hff00);
    close_out;
  end
endmodule // arcu_core_bench
